// ### hdl/uart_transmit_channel.sv
// Asynchronous transmit channel with Wishbone register access
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module uart_transmit_channel import uart_tx_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic serial_tx_line_o,
   output logic tx_interrupt_o
);
   logic [15:0] channel_mode_reg;
   logic [15:0] channel_operation_setting_reg;
   logic [15:0] channel_data_divisor_reg;
   logic [15:0] output_level_reg;
   logic [15:0] output_value_reg;
   logic [15:0] output_enable_reg;
   logic [7:0] prescaler_select_reg;
   logic buffer_full_flag;
   logic chan_on_reg;
   logic [14:0] presc_cnt_reg;
   tx_state_t st_reg;
   tx_state_t st_next;
   logic [8:0] shift_reg;
   logic [3:0] nbits_reg;
   logic [3:0] bit_cnt_reg;
   logic parity_reg;
   logic stop_cnt_reg;
   logic bit_end;

   // Bus decode
   wire logic req = cyc_i && stb_i && !ack_o;
   wire logic wr = req && we_i;
   wire logic [15:0] bmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
   wire logic wr_mode = wr && adr_i == OFS_MODE;
   wire logic wr_opset = wr && adr_i == OFS_OPSET;
   wire logic wr_data = wr && adr_i == OFS_DATA && sel_i[0];
   wire logic wr_level = wr && adr_i == OFS_LEVEL;
   wire logic wr_value = wr && adr_i == OFS_VALUE;
   wire logic wr_oe = wr && adr_i == OFS_OE;
   wire logic wr_start = wr && adr_i == OFS_START && sel_i[0] && dat_i[CH];
   wire logic wr_stop = wr && adr_i == OFS_STOP && sel_i[0] && dat_i[CH];
   wire logic wr_presc = wr && adr_i == OFS_PRESC && sel_i[0];
   wire logic [15:0] wdat = dat_i[15:0];

   // Live configuration fields
   wire logic cks = channel_mode_reg[MODE_CKS];
   wire logic md_empty = channel_mode_reg[MODE_MD];
   wire logic txe = channel_operation_setting_reg[OPSET_TXE];
   wire logic [1:0] par_mode = channel_operation_setting_reg[OPSET_PAR_HI:OPSET_PAR_LO];
   wire logic lsb_first = channel_operation_setting_reg[OPSET_LSB];
   wire logic two_stop =
      channel_operation_setting_reg[OPSET_STP_HI:OPSET_STP_LO] == STP_TWO;
   wire logic [1:0] len_sel = channel_operation_setting_reg[OPSET_LEN_HI:OPSET_LEN_LO];
   wire logic [6:0] divisor = channel_data_divisor_reg[DATA_DIV_HI:DATA_DIV_LO];
   wire logic inv = output_level_reg[CH];
   wire logic oe = output_enable_reg[CH];

   // Prescaler outputs: tick every 2^k system clocks
   wire logic [14:0] mask0 = ~(15'h7fff << prescaler_select_reg[3:0]);
   wire logic [14:0] mask1 = ~(15'h7fff << prescaler_select_reg[7:4]);
   wire logic prescaler_out_zero = &(presc_cnt_reg | ~mask0);
   wire logic prescaler_out_one = &(presc_cnt_reg | ~mask1);
   wire logic fmck_tick = cks ? prescaler_out_one : prescaler_out_zero;

   // Word length decode; prohibited code falls back to 8 bits
   wire logic [3:0] nbits_cfg = (len_sel == LEN_7) ? NBITS_7 :
      (len_sel == LEN_9) ? NBITS_9 : NBITS_8;

   // Bit order: MSB-first is turned into LSB-first at load so one shifter serves both
   logic [8:0] word_in;
   logic [8:0] word_ord;
   always_comb begin
      word_in = channel_data_divisor_reg[DATA_WORD_HI:0];
      if (nbits_cfg == NBITS_7) begin
         word_in[8:7] = 2'b00;
      end else if (nbits_cfg == NBITS_8) begin
         word_in[8] = 1'b0;
      end
      word_ord = word_in;
      if (!lsb_first) begin
         for (int i = 0; i < 9; i++) begin
            if (i < int'(nbits_cfg)) begin
               word_ord[i] = word_in[int'(nbits_cfg) - 1 - i];
            end else begin
               word_ord[i] = 1'b0;
            end
         end
      end
   end

   // Frame sequencing
   wire logic active = st_reg != ST_IDLE;
   wire logic last_data = bit_cnt_reg == nbits_reg - 4'd1;
   wire logic last_stop = !two_stop || stop_cnt_reg;
   wire logic frame_end = st_reg == ST_STOP && bit_end && last_stop;
   wire logic can_load = chan_on_reg && txe && buffer_full_flag;
   // Back-to-back frames: the next word loads at the end of the last stop bit
   wire logic load = can_load && (st_reg == ST_IDLE || frame_end);

   always_comb begin
      st_next = st_reg;
      case (st_reg)
         ST_IDLE: begin
            if (load) begin
               st_next = ST_START;
            end
         end
         ST_START: begin
            if (bit_end) begin
               st_next = ST_DATA;
            end
         end
         ST_DATA: begin
            if (bit_end && last_data) begin
               st_next = (par_mode == PAR_NONE) ? ST_STOP : ST_PARITY;
            end
         end
         ST_PARITY: begin
            if (bit_end) begin
               st_next = ST_STOP;
            end
         end
         ST_STOP: begin
            if (frame_end) begin
               st_next = load ? ST_START : ST_IDLE;
            end
         end
         default: st_next = ST_IDLE;
      endcase
      if (!chan_on_reg) begin
         st_next = ST_IDLE;
      end
   end

   // Level that the current state puts on the line, before inversion
   logic tx_level;
   always_comb begin
      case (st_reg)
         ST_START: tx_level = 1'b0;
         ST_DATA: tx_level = shift_reg[0];
         ST_PARITY: tx_level = parity_reg;
         default: tx_level = 1'b1;
      endcase
   end

   wire logic par_bit = (par_mode == PAR_EVEN) ? ^word_in :
      (par_mode == PAR_ODD) ? ~^word_in : 1'b0;

   bit_timer #(
      .DIV_W(7)
   ) u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(fmck_tick),
      .restart_i(load || !active),
      .div_i(divisor),
      .bit_end_o(bit_end)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= ST_IDLE;
         shift_reg <= '0;
         nbits_reg <= NBITS_8;
         bit_cnt_reg <= '0;
         parity_reg <= 1'b0;
         stop_cnt_reg <= 1'b0;
         presc_cnt_reg <= '0;
      end else begin
         st_reg <= st_next;
         presc_cnt_reg <= presc_cnt_reg + 15'd1;
         if (load) begin
            shift_reg <= word_ord;
            nbits_reg <= nbits_cfg;
            parity_reg <= par_bit;
            bit_cnt_reg <= '0;
            stop_cnt_reg <= 1'b0;
         end else if (bit_end && st_reg == ST_DATA) begin
            shift_reg <= {1'b0, shift_reg[8:1]};
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
         end else if (bit_end && st_reg == ST_STOP) begin
            stop_cnt_reg <= 1'b1;
         end
      end
   end

   // Registers, buffer flag and interrupt
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         channel_mode_reg <= RST_MODE;
         channel_operation_setting_reg <= RST_OPSET;
         channel_data_divisor_reg <= RST_DATA;
         output_level_reg <= RST_LEVEL;
         output_value_reg <= RST_VALUE;
         output_enable_reg <= RST_OE;
         prescaler_select_reg <= RST_PRESC;
         buffer_full_flag <= 1'b0;
         chan_on_reg <= 1'b0;
         tx_interrupt_o <= 1'b0;
      end else begin
         if (wr_mode) begin
            channel_mode_reg <= (channel_mode_reg & ~bmask) | (wdat & bmask);
         end
         if (wr_opset) begin
            channel_operation_setting_reg <=
               (channel_operation_setting_reg & ~bmask) | (wdat & bmask);
         end
         if (wr_data) begin
            // Overwrites any pending word; the earlier word is lost
            channel_data_divisor_reg <= (channel_data_divisor_reg & ~bmask) | (wdat & bmask);
         end
         if (wr_level) begin
            output_level_reg <= (output_level_reg & ~bmask) | (wdat & bmask);
         end
         if (wr_oe) begin
            output_enable_reg <= (output_enable_reg & ~bmask) | (wdat & bmask);
         end
         if (wr_presc) begin
            prescaler_select_reg <= dat_i[7:0];
         end
         // Hardware owns the line bit while sending with the output enabled; a software write then loses
         if (active && oe) begin
            output_value_reg <= {output_value_reg[15:1], tx_level ^ inv};
         end else if (wr_value) begin
            output_value_reg <= (output_value_reg & ~bmask) | (wdat & bmask);
         end
         // Set by a write wins over the clear by a load in the same cycle
         if (wr_data) begin
            buffer_full_flag <= 1'b1;
         end else if (load) begin
            buffer_full_flag <= 1'b0;
         end
         if (wr_stop) begin
            chan_on_reg <= 1'b0;
         end else if (wr_start) begin
            chan_on_reg <= 1'b1;
         end
         // Source bit is sampled at the event, so late changes still apply
         tx_interrupt_o <= (load && md_empty) || (frame_end && !md_empty);
      end
   end

   assign serial_tx_line_o = output_value_reg[CH];

   // Read mux and Wishbone answer, one cycle after the request
   logic [15:0] rd_mux;
   always_comb begin
      case (adr_i)
         OFS_MODE: rd_mux = channel_mode_reg;
         OFS_OPSET: rd_mux = channel_operation_setting_reg;
         OFS_DATA: rd_mux = channel_data_divisor_reg;
         OFS_LEVEL: rd_mux = output_level_reg;
         OFS_VALUE: rd_mux = output_value_reg;
         OFS_OE: rd_mux = output_enable_reg;
         OFS_STATE: rd_mux = {9'h000, active, 4'h0, chan_on_reg, buffer_full_flag};
         OFS_PRESC: rd_mux = {8'h00, prescaler_select_reg};
         default: rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= '0;
      end else begin
         ack_o <= req;
         dat_o <= req ? {16'h0000, rd_mux} : 32'h0000_0000;
      end
   end

   // Checks
   sequence s_last_stop_end;
      st_reg == ST_STOP && bit_end && last_stop;
   endsequence

   property p_start_level;
      @(posedge clk_i) disable iff (rst_i)
      st_reg == ST_START && $past(st_reg) == ST_START && oe && $stable(inv)
         |-> serial_tx_line_o == inv;
   endproperty
   a_start_level: assert property (p_start_level) else $error("start bit level wrong");

   property p_stop_level;
      @(posedge clk_i) disable iff (rst_i)
      st_reg == ST_STOP && $past(st_reg) == ST_STOP && oe && $stable(inv)
         |-> serial_tx_line_o == !inv;
   endproperty
   a_stop_level: assert property (p_stop_level) else $error("stop bit level wrong");

   property p_data_level;
      @(posedge clk_i) disable iff (rst_i)
      st_reg == ST_DATA && $past(st_reg) == ST_DATA && $stable(shift_reg) && oe && $stable(inv)
         |-> serial_tx_line_o == (shift_reg[0] ^ inv);
   endproperty
   a_data_level: assert property (p_data_level) else $error("data bit level wrong");

   property p_end_irq;
      @(posedge clk_i) disable iff (rst_i)
      s_last_stop_end and !md_empty |=> tx_interrupt_o;
   endproperty
   a_end_irq: assert property (p_end_irq) else $error("transfer end interrupt missing");

   property p_empty_irq;
      @(posedge clk_i) disable iff (rst_i)
      load && md_empty |=> tx_interrupt_o ##1 !tx_interrupt_o || load;
   endproperty
   a_empty_irq: assert property (p_empty_irq) else $error("buffer empty interrupt wrong");

   property p_overwrite;
      @(posedge clk_i) disable iff (rst_i)
      wr_data && buffer_full_flag && sel_i[1:0] == 2'b11
         |=> buffer_full_flag && channel_data_divisor_reg == $past(wdat);
   endproperty
   a_overwrite: assert property (p_overwrite) else $error("pending word not replaced");

   property p_data_count;
      @(posedge clk_i) disable iff (rst_i)
      st_reg == ST_DATA && bit_end && chan_on_reg
         |=> (st_reg == ST_DATA) == ($past(bit_cnt_reg) != $past(nbits_reg) - 4'd1);
   endproperty
   a_data_count: assert property (p_data_count) else $error("wrong number of data bits");

   property p_two_stop;
      @(posedge clk_i) disable iff (rst_i)
      st_reg == ST_STOP && bit_end && two_stop && !stop_cnt_reg && chan_on_reg
         |=> st_reg == ST_STOP ##0 stop_cnt_reg;
   endproperty
   a_two_stop: assert property (p_two_stop) else $error("second stop bit skipped");

   property p_clock_pick;
      @(posedge clk_i) disable iff (rst_i)
      !cks && prescaler_select_reg[3:0] == 4'h0 |-> fmck_tick;
   endproperty
   a_clock_pick: assert property (p_clock_pick) else $error("operation clock source wrong");
endmodule

// ### hdl/uart_tx_defs.sv
// Constants for the transmit channel and its bit-period timer
package uart_tx_pkg;
   localparam int ADR_W = 6;
   localparam logic [5:0] OFS_MODE = 6'h00;
   localparam logic [5:0] OFS_OPSET = 6'h04;
   localparam logic [5:0] OFS_DATA = 6'h08;
   localparam logic [5:0] OFS_LEVEL = 6'h0c;
   localparam logic [5:0] OFS_VALUE = 6'h10;
   localparam logic [5:0] OFS_OE = 6'h14;
   localparam logic [5:0] OFS_START = 6'h18;
   localparam logic [5:0] OFS_STATE = 6'h1c;
   localparam logic [5:0] OFS_PRESC = 6'h20;
   localparam logic [5:0] OFS_STOP = 6'h24;
   localparam logic [15:0] RST_MODE = 16'h0000;
   localparam logic [15:0] RST_OPSET = 16'h0087;
   localparam logic [15:0] RST_DATA = 16'h0000;
   localparam logic [15:0] RST_LEVEL = 16'h0000;
   localparam logic [15:0] RST_VALUE = 16'h0001;
   localparam logic [15:0] RST_OE = 16'h0000;
   localparam logic [7:0] RST_PRESC = 8'h00;
   localparam int CH = 0;
   localparam int MODE_CKS = 15;
   localparam int MODE_MD = 0;
   localparam int OPSET_TXE = 15;
   localparam int OPSET_PAR_HI = 9;
   localparam int OPSET_PAR_LO = 8;
   localparam int OPSET_LSB = 7;
   localparam int OPSET_STP_HI = 5;
   localparam int OPSET_STP_LO = 4;
   localparam int OPSET_LEN_HI = 1;
   localparam int OPSET_LEN_LO = 0;
   localparam int DATA_DIV_HI = 15;
   localparam int DATA_DIV_LO = 9;
   localparam int DATA_WORD_HI = 8;
   localparam int STATE_FULL = 0;
   localparam int STATE_EN = 1;
   localparam int STATE_BUSY = 6;
   localparam logic [1:0] PAR_NONE = 2'b00;
   localparam logic [1:0] PAR_ZERO = 2'b01;
   localparam logic [1:0] PAR_EVEN = 2'b10;
   localparam logic [1:0] PAR_ODD = 2'b11;
   localparam logic [1:0] STP_TWO = 2'b10;
   localparam logic [1:0] LEN_7 = 2'b10;
   localparam logic [1:0] LEN_9 = 2'b01;
   localparam logic [3:0] NBITS_7 = 4'd7;
   localparam logic [3:0] NBITS_8 = 4'd8;
   localparam logic [3:0] NBITS_9 = 4'd9;
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_START = 5'b00010,
      ST_DATA = 5'b00100,
      ST_PARITY = 5'b01000,
      ST_STOP = 5'b10000
   } tx_state_t;
endpackage

`timescale 1ns/1ns
module bit_timer import uart_tx_pkg::*; #(
   parameter int DIV_W = 7
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire logic restart_i,
   input wire logic [DIV_W-1:0] div_i,
   output logic bit_end_o
);
   logic [DIV_W:0] cnt_reg;
   wire logic [DIV_W:0] last = {div_i, 1'b1};
   wire logic at_end = tick_i && (cnt_reg == last);

   // Period is 2*(div+1) operation-clock ticks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= '0;
         bit_end_o <= 1'b0;
      end else if (restart_i) begin
         // Count this tick, so the start bit is not one tick longer than the rest
         cnt_reg <= {{DIV_W{1'b0}}, tick_i};
         bit_end_o <= 1'b0;
      end else begin
         bit_end_o <= at_end;
         if (at_end) begin
            cnt_reg <= '0;
         end else if (tick_i) begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end

   property p_bit_end_cause;
      @(posedge clk_i) disable iff (rst_i)
      bit_end_o |-> $past(tick_i) && $past(cnt_reg) == $past(last) && !$past(restart_i);
   endproperty
   a_bit_end_cause: assert property (p_bit_end_cause) else $error("bit end without terminal tick");
endmodule

// ### bench/serial_receiver_model.sv
// Far-end receiver model that decodes frames seen on the transmit line
`timescale 1ns/1ns
module serial_receiver_model import uart_tx_pkg::*; (
   input wire logic clk_i,
   input wire logic en_i,
   input wire logic line_i,
   input wire logic inv_i,
   input wire logic [15:0] cfg_i,
   input wire logic [15:0] bit_i,
   output logic [8:0] word_o,
   output logic par_o,
   output logic stop_ok_o,
   output logic [7:0] frames_o
);
   logic lvl;
   logic [8:0] sh;
   logic [3:0] nbits;
   logic two;
   int i;
   assign lvl = line_i ^ inv_i;
   assign nbits = (cfg_i[OPSET_LEN_HI:OPSET_LEN_LO] == LEN_7) ? 4'h7 :
                  (cfg_i[OPSET_LEN_HI:OPSET_LEN_LO] == LEN_9) ? 4'h9 : 4'h8;
   assign two = (cfg_i[OPSET_STP_HI:OPSET_STP_LO] == STP_TWO);
   initial begin
      word_o = 9'h000;
      par_o = 1'b0;
      stop_ok_o = 1'b0;
      frames_o = 8'h00;
      forever begin
         @(posedge clk_i);
         // Disabled while software reconfigures, so a level change is no start bit
         if (en_i === 1'b1 && lvl === 1'b0) begin
            // Sample mid-bit so a one-tick prescaler skew does not matter
            repeat (bit_i / 2) @(posedge clk_i);
            sh = 9'h000;
            for (i = 0; i < nbits; i++) begin
               repeat (bit_i) @(posedge clk_i);
               if (cfg_i[OPSET_LSB]) begin
                  sh[i] = lvl;
               end else begin
                  sh = {sh[7:0], lvl};
               end
            end
            par_o = 1'b0;
            if (cfg_i[OPSET_PAR_HI:OPSET_PAR_LO] != PAR_NONE) begin
               repeat (bit_i) @(posedge clk_i);
               par_o = lvl;
            end
            stop_ok_o = 1'b1;
            for (i = 0; i < (two ? 2 : 1); i++) begin
               repeat (bit_i) @(posedge clk_i);
               stop_ok_o = stop_ok_o & lvl;
            end
            word_o = sh;
            frames_o = frames_o + 8'h01;
         end
      end
   end
endmodule

// ### bench/uart_transmit_channel_tb.sv
// Self-checking bench for the transmit channel
`timescale 1ns/1ns
module uart_transmit_channel_tb import uart_tx_pkg::*; ;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [ADR_W-1:0] adr_i = '0;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000;
   logic [31:0] dat_o;
   logic ack_o;
   logic serial_tx_line_o;
   logic tx_interrupt_o;
   logic p_en = 1'b0;
   logic p_inv = 1'b0;
   logic [15:0] p_cfg = 16'h0000;
   logic [15:0] p_bit = 16'h0006;
   logic [8:0] rx_word;
   logic rx_par;
   logic rx_stop;
   logic [7:0] frames;
   logic [15:0] q;
   int irqs = 0;
   int failures = 0;
   int checked = 0;

   always #20 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (tx_interrupt_o === 1'b1) begin
         irqs <= irqs + 1;
      end
   end

   uart_transmit_channel u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .serial_tx_line_o(serial_tx_line_o), .tx_interrupt_o(tx_interrupt_o));

   serial_receiver_model u_far (.clk_i(clk_i), .en_i(p_en), .line_i(serial_tx_line_o),
      .inv_i(p_inv), .cfg_i(p_cfg), .bit_i(p_bit), .word_o(rx_word), .par_o(rx_par),
      .stop_ok_o(rx_stop), .frames_o(frames));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         failures++;
      end
      checked++;
   endtask

   // Bounded wait: a stuck slave must not hang the run
   task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [15:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'hf;
      dat_i <= {16'h0000, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      if (ack_o !== 1'b1) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, ack_o, 1'b1);
         failures++;
      end
      q = dat_o[15:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      sel_i <= 4'h0;
      @(posedge clk_i);
   endtask

   task automatic wait_frames(input logic [7:0] target);
      int n;
      n = 0;
      while (frames !== target && n < 4000) begin
         @(posedge clk_i);
         n++;
      end
      if (frames !== target) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, frames, target);
         failures++;
      end
   endtask

   task automatic wrap_up();
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic regs_test();
      logic [5:0] ofs [6];
      logic [15:0] rv [6];
      ofs = '{OFS_MODE, OFS_OPSET, OFS_DATA, OFS_LEVEL, OFS_VALUE, OFS_OE};
      rv = '{RST_MODE, RST_OPSET, RST_DATA, RST_LEVEL, RST_VALUE, RST_OE};
      chk(serial_tx_line_o, 1'b1);
      for (int k = 0; k < 6; k++) begin
         wb(1'b0, ofs[k], 16'h0000);
         chk(q, rv[k]);
      end
      wb(1'b0, 6'h3c, 16'h0000);
      chk(q, 16'h0000);
      wb(1'b1, OFS_VALUE, 16'h0000);
      repeat (2) @(posedge clk_i);
      chk(serial_tx_line_o, 1'b0);
      wb(1'b1, OFS_VALUE, 16'h0001);
      repeat (2) @(posedge clk_i);
      chk(serial_tx_line_o, 1'b1);
      wb(1'b1, OFS_START, 16'h0002);
      wb(1'b0, OFS_STATE, 16'h0000);
      chk(q[STATE_EN], 1'b0);
   endtask

   task automatic frame(input logic [15:0] cfg, input logic inv, input logic cks,
         input logic [6:0] div, input logic [8:0] w, input logic [8:0] ew, input logic ep);
      int i0;
      logic [7:0] f0;
      p_en <= 1'b0;
      wb(1'b1, OFS_MODE, {cks, 15'h0000});
      wb(1'b1, OFS_OPSET, cfg);
      wb(1'b1, OFS_LEVEL, {15'h0000, inv});
      wb(1'b1, OFS_VALUE, {15'h0000, ~inv});
      wb(1'b1, OFS_OE, 16'h0001);
      wb(1'b1, OFS_START, 16'h0001);
      p_cfg <= cfg;
      p_inv <= inv;
      p_bit <= (16'(div) + 16'h0001) * (cks ? 16'h0004 : 16'h0002);
      p_en <= 1'b1;
      i0 = irqs;
      f0 = frames;
      wb(1'b1, OFS_DATA, {div, w});
      wait_frames(f0 + 8'h01);
      repeat (40) @(posedge clk_i);
      chk(rx_word, ew);
      chk(rx_par, ep);
      chk(rx_stop, 1'b1);
      chk(16'(irqs - i0), 16'h0001);
   endtask

   // Runs on from the last frame's setup: two-clock ticks, 12-clock bits
   task automatic burst();
      logic [7:0] f0;
      int i0;
      f0 = frames;
      i0 = irqs;
      wb(1'b1, OFS_MODE, 16'h8001);
      wb(1'b1, OFS_DATA, {7'h02, 9'h011});
      wb(1'b1, OFS_DATA, {7'h02, 9'h022});
      wb(1'b0, OFS_STATE, 16'h0000);
      chk(q[STATE_FULL], 1'b1);
      wb(1'b1, OFS_DATA, {7'h02, 9'h033});
      wait_frames(f0 + 8'h01);
      chk(rx_word, 9'h011);
      repeat (12) @(posedge clk_i);
      wb(1'b1, OFS_MODE, 16'h8000);
      wait_frames(f0 + 8'h02);
      repeat (40) @(posedge clk_i);
      chk(rx_word, 9'h033);
      chk(16'(irqs - i0), 16'h0003);
   endtask

   // Cut a frame, reset the unit, let the far end finish, then set up from scratch
   task automatic stop_reset();
      logic [7:0] f0;
      f0 = frames;
      wb(1'b1, OFS_DATA, {7'h02, 9'h0f0});
      repeat (30) @(posedge clk_i);
      wb(1'b0, OFS_STATE, 16'h0000);
      chk(q[STATE_BUSY], 1'b1);
      wb(1'b1, OFS_STOP, 16'h0001);
      wb(1'b0, OFS_STATE, 16'h0000);
      chk(q, 16'h0000);
      rst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk(serial_tx_line_o, 1'b1);
      wait_frames(f0 + 8'h01);
      frame(16'h8221, 1'b1, 1'b0, 7'h02, 9'h1a6, 9'h1a6, 1'b1);
   endtask

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      regs_test();
      wb(1'b1, OFS_PRESC, 16'h0010);
      frame(16'h8093, 1'b0, 1'b0, 7'h02, 9'h0a5, 9'h0a5, 1'b0);
      frame(16'h8212, 1'b1, 1'b0, 7'h03, 9'h0db, 9'h05b, 1'b1);
      frame(16'h83a1, 1'b0, 1'b0, 7'h02, 9'h1c3, 9'h1c3, 1'b0);
      frame(16'h8113, 1'b0, 1'b1, 7'h02, 9'h0ff, 9'h0ff, 1'b0);
      burst();
      stop_reset();
      wrap_up();
   end

   initial begin
      repeat (10000) @(posedge clk_i);
      failures++;
      wrap_up();
   end
endmodule
